// >>> common/cip_map.vh
/*
   Constants for the configurable I/O port block: register indices, field
   codes, reset values and timing counts. Holds definitions only and is
   included by its bare name.
*/
// Overview of operation
// [R01] Each pin picks its mode from two select bits: quasi, push-pull, input, open-drain.
// [R02] Tristate fuse enabled: every pin leaves reset in input-only mode.
// [R03] Fuse disabled: non-analog pins leave reset quasi-bidirectional with latch high.
// [R04] Port 0 and port 2 bits 4 to 7 always reset to input-only.
// [R05] Power-down disables input buffers except interrupt, reset and oscillator pins.
// [R06] Port 1 pins enabled as interrupt inputs keep input buffers in power-down.
// [R07] Outside circuitry must not leave wake-capable pins floating in power-down.
// [R08] Quasi mode: very weak pull-up on whenever the latch holds one.
// [R09] Quasi mode: weak pull-up on only while latch and sensed pin are one.
// [R10] Quasi mode: latch rising zero to one gives exactly two cycles of strong pull-up.
// [R11] Quasi mode: latch zero turns the strong pull-down on.
// [R12] Input-only mode: both drivers off, input still readable.
// [R13] Open-drain: no pull-ups; pull-down only while latch holds zero.
// [R14] Outside circuitry supplies the pull-up for an open-drain high.
// [R15] Push-pull: continuous strong pull-up for one, strong pull-down for zero.
// [R16] Usable pins are 35 to 38 depending on clock source and reset pin.
// [R17] Plain port reads return pin levels; latch view serves read-modify-write.
// [R18] Latch and mode writes reach the drivers at the next clock edge.
`ifndef CIP_MAP_VH
`define CIP_MAP_VH

// Register indices; byte address is four times the index.
`define CIP_IDX_PORT0_LATCH   9'h080
`define CIP_IDX_PORT1_LATCH   9'h090
`define CIP_IDX_PORT2_LATCH   9'h0A0
`define CIP_IDX_PORT3_LATCH   9'h0B0
`define CIP_IDX_PORT4_LATCH   9'h0C0
`define CIP_IDX_PORT0_MODE_LO 9'h0BA
`define CIP_IDX_PORT0_MODE_HI 9'h0BB
`define CIP_IDX_PORT4_MODE_LO 9'h0BE
`define CIP_IDX_PORT4_MODE_HI 9'h0BF
`define CIP_IDX_PORT1_MODE_LO 9'h0C2
`define CIP_IDX_PORT1_MODE_HI 9'h0C3
`define CIP_IDX_PORT2_MODE_LO 9'h0C4
`define CIP_IDX_PORT2_MODE_HI 9'h0C5
`define CIP_IDX_PORT3_MODE_LO 9'h0C6
`define CIP_IDX_PORT3_MODE_HI 9'h0C7
// Latch view for read-modify-write, one word per port from this index.
`define CIP_IDX_LATCH_VIEW 9'h100

// Reset values.
`define CIP_LATCH_RST      8'hFF
`define CIP_ANALOG_PORT0   8'hFF
`define CIP_ANALOG_PORT2   8'hF0
`define CIP_PORT4_EXIST    8'h3F

// Clock source codes.
`define CIP_CLK_INTERNAL   2'h0
`define CIP_CLK_EXTERNAL   2'h1
`define CIP_CLK_CRYSTAL    2'h2

// Timing and counts.
`define CIP_SPU_CYCLES     2'h2
`define CIP_IO_MAX         6'h26

// Bus responses.
`define CIP_RESP_OKAY      2'h0
`define CIP_RESP_SLVERR    2'h2

`endif

// >>> src/cip_port.v
/*
   Five-port general-purpose I/O control with per-pin mode selection,
   an AXI4-Lite register slave and per-pin driver controls.
   Assumes pad buffers outside turn the driver controls into pin levels
   and return the sensed level on pad_in, and that pwr_down and gpi_en
   come from logic on aclk.
*/
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cip_map.vh"

module cip_port #(
   parameter ADDR_W = 12
) (
   // Clock, reset, enable
   input  wire              aclk,
   input  wire              aresetn,
   input  wire              ce,
   // Write address
   input  wire [ADDR_W-1:0] awaddr,
   input  wire              awvalid,
   output wire              awready,
   // Write data
   input  wire [31:0]       wdata,
   input  wire [3:0]        wstrb,
   input  wire              wvalid,
   output wire              wready,
   // Write response
   output reg  [1:0]        bresp,
   output reg               bvalid,
   input  wire              bready,
   // Read address
   input  wire [ADDR_W-1:0] araddr,
   input  wire              arvalid,
   output wire              arready,
   // Read data
   output reg  [31:0]       rdata,
   output reg  [1:0]        rresp,
   output reg               rvalid,
   input  wire              rready,
   // Device options
   input  wire              tristate_fuse,
   input  wire [1:0]        clk_src,
   input  wire              ext_rst_en,
   input  wire              pwr_down,
   input  wire [7:0]        gpi_en,
   // Pins
   input  wire [39:0]       pad_in,
   output wire [39:0]       very_weak_pu,
   output wire [39:0]       weak_pu,
   output wire [39:0]       strong_pu,
   output wire [39:0]       pull_down,
   output wire [39:0]       in_buf_en,
   output reg  [5:0]        io_count
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   reg  [7:0]  latch   [0:4];
   reg  [7:0]  mode_lo [0:4];
   reg  [7:0]  mode_hi [0:4];
   reg  [39:0] pad_s1;
   reg  [39:0] pad_s2;

   reg              aw_full;
   reg [ADDR_W-1:0] aw_addr;
   reg              w_full;
   reg [7:0]        w_byte;
   reg              w_en;

   integer k;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // Result: {hit, kind[1:0], port[2:0]}; kind 0 latch, 1 lo, 2 hi, 3 view.
   function [5:0] dec;
      input [8:0] idx;
      begin
         case (idx)
            `CIP_IDX_PORT0_LATCH:   dec = 6'h20;
            `CIP_IDX_PORT1_LATCH:   dec = 6'h21;
            `CIP_IDX_PORT2_LATCH:   dec = 6'h22;
            `CIP_IDX_PORT3_LATCH:   dec = 6'h23;
            `CIP_IDX_PORT4_LATCH:   dec = 6'h24;
            `CIP_IDX_PORT0_MODE_LO: dec = 6'h28;
            `CIP_IDX_PORT1_MODE_LO: dec = 6'h29;
            `CIP_IDX_PORT2_MODE_LO: dec = 6'h2A;
            `CIP_IDX_PORT3_MODE_LO: dec = 6'h2B;
            `CIP_IDX_PORT4_MODE_LO: dec = 6'h2C;
            `CIP_IDX_PORT0_MODE_HI: dec = 6'h30;
            `CIP_IDX_PORT1_MODE_HI: dec = 6'h31;
            `CIP_IDX_PORT2_MODE_HI: dec = 6'h32;
            `CIP_IDX_PORT3_MODE_HI: dec = 6'h33;
            `CIP_IDX_PORT4_MODE_HI: dec = 6'h34;
            default:
            begin
               if (idx >= `CIP_IDX_LATCH_VIEW && idx <= `CIP_IDX_LATCH_VIEW + 9'h004)
                  dec = {3'h7, idx[2:0]};
               else
                  dec = 6'h00;
            end
         endcase
      end
   endfunction

   wire [5:0] wdec = dec(aw_addr[10:2]);
   wire [5:0] rdec = dec(araddr[10:2]);
   wire       do_write = aw_full & w_full & ~bvalid;
   wire       wr_kind_ok = (wdec[4:3] != 2'h3);

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   // Address and data are held separately so they may arrive in either order.
   assign awready = ~aw_full & ~bvalid;
   assign wready  = ~w_full & ~bvalid;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full <= 1'b0;
         aw_addr <= {ADDR_W{1'b0}};
         w_full  <= 1'b0;
         w_byte  <= 8'h00;
         w_en    <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= `CIP_RESP_OKAY;
      end
      else if (ce)
      begin
         if (awvalid && awready)
         begin
            aw_full <= 1'b1;
            aw_addr <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_full <= 1'b1;
            w_byte <= wdata[7:0];
            w_en   <= wstrb[0];
         end
         if (do_write)
         begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= (wdec[5] && wr_kind_ok) ? `CIP_RESP_OKAY : `CIP_RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Port registers
   // ---------------------------------------------------------------
   // The fuse is a static option, so sampling it in the synchronous reset
   // branch is safe; analog pins ignore it.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (k = 0; k < 5; k = k + 1)
         begin
            latch[k]   <= `CIP_LATCH_RST;                        // see [R03]
            mode_hi[k] <= 8'h00;                                 // see [R01]
            mode_lo[k] <= tristate_fuse ? 8'hFF : 8'h00;         // see [R02]
         end
         if (!tristate_fuse)
         begin
            mode_lo[0] <= `CIP_ANALOG_PORT0;                     // see [R04]
            mode_lo[2] <= `CIP_ANALOG_PORT2;                     // see [R04]
         end
      end
      else if (ce && do_write && wdec[5] && w_en)
      begin
         // Registers change on this edge, so drivers follow at once.
         case (wdec[4:3])                                        // see [R18]
            2'h0:    latch[wdec[2:0]]   <= w_byte;
            2'h1:    mode_lo[wdec[2:0]] <= w_byte;
            2'h2:    mode_hi[wdec[2:0]] <= w_byte;
            default: latch[0] <= latch[0];
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pin input synchroniser
   // ---------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pad_s1 <= 40'h00_0000_0000;
         pad_s2 <= 40'h00_0000_0000;
      end
      else if (ce)
      begin
         pad_s1 <= pad_in;
         pad_s2 <= pad_s1;
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   assign arready = ~rvalid;

   wire [39:0] pin_lvl = pad_s2;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `CIP_RESP_OKAY;
      end
      else if (ce)
      begin
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rresp  <= rdec[5] ? `CIP_RESP_OKAY : `CIP_RESP_SLVERR;
            rdata  <= 32'h0000_0000;
            if (rdec[5])
            begin
               case (rdec[4:3])
                  2'h0:    rdata[7:0] <= pin_lvl[rdec[2:0]*8 +: 8];    // see [R17]
                  2'h1:    rdata[7:0] <= mode_lo[rdec[2:0]];
                  2'h2:    rdata[7:0] <= mode_hi[rdec[2:0]];
                  default: rdata[7:0] <= latch[rdec[2:0]];             // see [R17]
               endcase
            end
         end
         else if (rvalid && rready)
            rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Pins taken by clock and reset
   // ---------------------------------------------------------------
   wire take_osc_in  = (clk_src != `CIP_CLK_INTERNAL);
   wire take_osc_out = (clk_src == `CIP_CLK_CRYSTAL);

   always @(posedge aclk)
   begin
      if (!aresetn)
         io_count <= `CIP_IO_MAX;
      else if (ce)
         io_count <= `CIP_IO_MAX - {5'h00, take_osc_in} - {5'h00, take_osc_out}
                     - {5'h00, ext_rst_en};                      // see [R16]
   end

   // Wake-capable pins: port 3 bits 2 and 3, port 4 bits 0 to 2.
   wire [39:0] wake_mask = {5'h00, 3'h7, 4'h0, 2'h3, 2'h0, 24'h00_0000};
   // Pins carrying the oscillator or reset lose their drivers.
   wire [39:0] claimed   = {5'h00, ext_rst_en, take_osc_out, take_osc_in, 32'h0000_0000};
   wire [39:0] exists    = {`CIP_PORT4_EXIST, 32'hFFFF_FFFF};

   // ---------------------------------------------------------------
   // Per-pin driver control
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 40; i = i + 1)
      begin : g_pin
         wire       lo    = mode_lo[i/8][i%8];
         wire       hi    = mode_hi[i/8][i%8];
         wire       lat   = latch[i/8][i%8];
         wire       live  = exists[i] & ~claimed[i];
         wire       quasi = ~lo & ~hi & live;                    // see [R01]
         wire       pp    = ~lo &  hi & live;                    // see [R01]
         wire       odr   =  lo &  hi & live;                    // see [R01]
         reg        lat_d;
         reg  [1:0] spu_cnt;
         wire       rise  = quasi & lat & ~lat_d;

         always @(posedge aclk)
         begin
            if (!aresetn)
            begin
               lat_d   <= 1'b1;
               spu_cnt <= 2'h0;
            end
            else if (ce)
            begin
               lat_d <= lat;
               // The rise cycle itself is the first of the pulse.
               if (rise)
                  spu_cnt <= `CIP_SPU_CYCLES - 2'h1;             // see [R10]
               else if (spu_cnt != 2'h0)
                  spu_cnt <= spu_cnt - 2'h1;
            end
         end

         assign very_weak_pu[i] = quasi & lat;                   // see [R08]
         assign weak_pu[i]      = quasi & lat & pin_lvl[i];      // see [R09]
         // Open-drain and input-only never reach a pull-up here.
         // A latch cleared mid-pulse ends the pulse, so it never fights the pull-down.
         assign strong_pu[i]    = (quasi & lat & (rise | (spu_cnt != 2'h0)))   // see [R10]
                                | (pp & lat);                    // see [R15]
         // Same pull-down for quasi, push-pull and open-drain; none in input-only.
         assign pull_down[i]    = (quasi | pp | odr) & ~lat;     // see [R11] [R13] [R15] [R12]
         assign in_buf_en[i]    = exists[i] & (~pwr_down | wake_mask[i]   // see [R05]
                                | ((i / 8 == 1) ? gpi_en[i%8] : 1'b0));  // see [R06]
      end
   endgenerate

endmodule // cip_port

`default_nettype wire

// >>> verification/cip_pins.sv
/*
   Board model for the port pins: outside pull-ups and devices pulling low.
   Assumes the port block's pull-down controls and the bench's ext_low.
*/
`timescale 1ns/1ps
`default_nettype none

module cip_pins (
   // From the port block
   input  wire logic [39:0] pull_down,
   // Outside devices sinking current
   input  wire logic [39:0] ext_low,
   // Sensed levels
   output      logic [39:0] pad_in
);
   // Every pin has a resistor to the supply, so none floats.
   assign pad_in = ~(pull_down | ext_low);
endmodule // cip_pins

`default_nettype wire

// >>> verification/cip_port_monitor.sv
/*
   Concurrent checks on the pin controls and status of the port block.
   Assumes binding to cip_port; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module cip_port_monitor (
   // Clock, reset, options
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   input wire logic [1:0]  clk_src,
   input wire logic        ext_rst_en,
   input wire logic        pwr_down,
   input wire logic [7:0]  gpi_en,
   // Pins
   input wire logic [39:0] pad_in,
   input wire logic [39:0] very_weak_pu,
   input wire logic [39:0] weak_pu,
   input wire logic [39:0] strong_pu,
   input wire logic [39:0] pull_down,
   input wire logic [39:0] in_buf_en,
   input wire logic [5:0]  io_count
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [39:0]      prev_vw_v;
   wire  logic [39:0] q_rise = strong_pu & very_weak_pu & ~prev_vw_v;
   wire  logic [39:0] wake = {5'h00, 3'h7, 4'h0, 2'h3, 10'h000, gpi_en, 8'h00};

   // A quasi pin starting its strong pulse shows very weak rising alongside.
   always @(posedge aclk)
      prev_vw_v <= very_weak_pu;

   no_fight_a: assert property ((pull_down & (very_weak_pu | weak_pu | strong_pu)) == 40'h0)
      else $error("pull-down on with a pull-up");
   weak_latch_a: assert property ((weak_pu & ~very_weak_pu) == 40'h0)
      else $error("weak pull-up without latch high");
   weak_pad_a: assert property ($past(ce) && $past(ce, 2) |-> (weak_pu & ~$past(pad_in, 2)) == 40'h0)
      else $error("weak pull-up on a low pin");
   spu_two_a: assert property (q_rise != 40'h0 |=> ((strong_pu & $past(q_rise)) == $past(q_rise))
      ##1 ((strong_pu & $past(q_rise, 2)) == 40'h0))
      else $error("strong pulse not two cycles");
   wake_bufs_a: assert property (pwr_down |-> in_buf_en == wake)
      else $error("wrong buffers in power-down");
   awake_bufs_a: assert property (!pwr_down |-> in_buf_en == 40'h3F_FFFF_FFFF)
      else $error("input buffer off while awake");
   ghost_pins_a: assert property ({very_weak_pu[39:38], weak_pu[39:38], strong_pu[39:38],
      pull_down[39:38], in_buf_en[39:38]} == 10'h000)
      else $error("absent pin has a control on");
   io_count_a: assert property ($past(ce) |-> io_count == 6'h26 - {4'h0, $past(clk_src)}
      - {5'h00, $past(ext_rst_en)})
      else $error("wrong usable pin count");
endmodule // cip_port_monitor

bind cip_port cip_port_monitor MON (.aclk(aclk), .aresetn(aresetn), .ce(ce), .clk_src(clk_src),
   .ext_rst_en(ext_rst_en), .pwr_down(pwr_down), .gpi_en(gpi_en), .pad_in(pad_in),
   .very_weak_pu(very_weak_pu), .weak_pu(weak_pu), .strong_pu(strong_pu), .pull_down(pull_down),
   .in_buf_en(in_buf_en), .io_count(io_count));

`default_nettype wire

// >>> verification/cip_port_tb.sv
/*
   Self-checking bench for cip_port: reset modes, pin drivers, reads, counts.
   Assumes cip_pins as the board and the bound monitor.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cip_map.vh"

module cip_port_tb;
   logic        aclk, aresetn, awvalid, wvalid, arvalid, fuse, ext_rst_en, pwr_down;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, clk_src;
   logic [7:0]  gpi_en, d, v, e, x;
   logic [39:0] ext_low, pad_in, vw, wk, spu, pd, ibuf;
   logic [5:0]  io_count;
   logic [8:0]  lat_i [4] = '{`CIP_IDX_PORT0_LATCH, `CIP_IDX_PORT1_LATCH, `CIP_IDX_PORT2_LATCH,
                              `CIP_IDX_PORT3_LATCH};
   logic [8:0]  lo_i [4] = '{`CIP_IDX_PORT0_MODE_LO, `CIP_IDX_PORT1_MODE_LO, `CIP_IDX_PORT2_MODE_LO,
                             `CIP_IDX_PORT3_MODE_LO};
   int          err_count, total_checks, p, m;

   cip_port DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .tristate_fuse(fuse), .clk_src(clk_src),
      .ext_rst_en(ext_rst_en), .pwr_down(pwr_down), .gpi_en(gpi_en), .pad_in(pad_in), .very_weak_pu(vw),
      .weak_pu(wk), .strong_pu(spu), .pull_down(pd), .in_buf_en(ibuf), .io_count(io_count));
   cip_pins BOARD (.pull_down(pd), .ext_low(ext_low), .pad_in(pad_in));

   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // -----------------------------------------------------------------
   // Bus tasks and expectations
   // -----------------------------------------------------------------
   task automatic chk(input string n, input logic [39:0] s, input logic [39:0] ex);
      total_checks++;
      if (s !== ex)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, ex, s);
      end
   endtask

   task automatic wr(input logic [8:0] i, input logic [7:0] dv, input logic [1:0] er);
      awaddr <= {1'b0, i, 2'b00};
      wdata <= {24'h000000, dv};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      chk("bresp", 40'(bresp), 40'(er));
   endtask

   task automatic rd(input logic [8:0] i, output logic [7:0] dv, input logic [1:0] er);
      araddr <= {1'b0, i, 2'b00};
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      dv = rdata[7:0];
      chk("rresp", 40'(rresp), 40'(er));
   endtask

   task automatic rst(input logic f);
      fuse <= f;
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   // Returns very weak, weak, strong and pull-down bytes once the pulse is over.
   function automatic logic [31:0] ctl(input int md, input logic [7:0] l, input logic [7:0] lo);
      case (md)
         0: return {l, l & ~lo, 8'h00, ~l};
         1: return {8'h00, 8'h00, l, ~l};
         2: return 32'h0000_0000;
         default: return {24'h000000, ~l};
      endcase
   endfunction

   task print_verdict;
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge aclk);
      err_count++;
      print_verdict;
   end

   initial
   begin
      {aresetn, awvalid, wvalid, arvalid, fuse, ext_rst_en, pwr_down} = 7'h00;
      {awaddr, araddr, wdata, clk_src, gpi_en, ext_low} = 106'h0;
      void'($urandom(68632));
      for (int f = 0; f < 2; f++)
      begin
         rst(f[0]);
         for (p = 0; p < 4; p++)
         begin
            e = (f == 1 || p == 0) ? 8'hFF : (p == 2) ? 8'hF0 : 8'h00;
            rd(lo_i[p], v, 2'h0);
            chk("mode_lo", 40'(v), 40'(e));
            rd(lo_i[p] + 9'h001, v, 2'h0);
            chk("mode_hi", 40'(v), 40'h0);
            rd(`CIP_IDX_LATCH_VIEW + 9'(p), v, 2'h0);
            chk("reset_latch", 40'(v), 40'hFF);
            chk("very_weak", {32'h0, vw[8*p+:8]}, {32'h0, ~e});
         end
      end
      for (int i = 0; i < 8; i++)
      begin
         m = i % 4;
         p = $urandom_range(3);
         d = 8'($urandom);
         x = 8'($urandom);
         ext_low <= 40'(x) << (8 * p);
         wr(lat_i[p], 8'h00, 2'h0);
         wr(lo_i[p], {8{m[1]}}, 2'h0);
         wr(lo_i[p] + 9'h001, {8{m[0]}}, 2'h0);
         wr(lat_i[p], d, 2'h0);
         #1 chk("strong_pulse", 40'(spu[8*p+:8]), 40'((m < 2) ? d : 8'h00));
         @(posedge aclk);
         #1 chk("strong_end", 40'(spu[8*p+:8]), 40'((m == 1) ? d : 8'h00));
         repeat (3) @(posedge aclk);
         chk("drivers", 40'({vw[8*p+:8], wk[8*p+:8], spu[8*p+:8], pd[8*p+:8]}), 40'(ctl(m, d, x)));
         rd(lat_i[p], v, 2'h0);
         chk("pin_read", 40'(v), {32'h0, ~(8'(ctl(m, d, x)) | x)});
         rd(`CIP_IDX_LATCH_VIEW + 9'(p), v, 2'h0);
         chk("latch_view", 40'(v), 40'(d));
      end
      gpi_en <= 8'($urandom);
      pwr_down <= 1'b1;
      repeat (4) @(posedge aclk);
      #1 chk("wake_bufs", ibuf, {5'h00, 3'h7, 4'h0, 2'h3, 10'h000, gpi_en, 8'h00});
      @(posedge aclk);
      pwr_down <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         clk_src <= 2'(i / 2);
         ext_rst_en <= i[0];
         repeat (2) @(posedge aclk);
         #1 chk("io_count", 40'(io_count), 40'(38 - i / 2 - i % 2));
         @(posedge aclk);
      end
      wr(9'h001, 8'h55, 2'h2);
      rd(9'h001, v, 2'h2);
      chk("bad_rdata", 40'(v), 40'h0);
      wr(`CIP_IDX_LATCH_VIEW, 8'h00, 2'h2);
      print_verdict;
   end
endmodule // cip_port_tb

`default_nettype wire
